//--- verilog/dsp_pkg.sv
// Package for the data-space page and stack check block.
// Assumes a single core clock domain; all users import dsp_pkg::*.
package dsp_pkg;

  // Address space figures.
  localparam int             ADDR_W       = 16;
  localparam int             EXT_W        = 24;
  localparam int             PAGE_W       = 9;
  localparam logic [15:0]    PAGED_BASE   = 16'h8000;
  localparam logic [15:0]    NEAR_TOP     = 16'h1fff;
  localparam logic [15:0]    SFR_TOP      = 16'h0800;
  localparam logic [8:0]     PAGE_INVALID = 9'h000;
  localparam logic [7:0]     EXT_HI_ZERO  = 8'h00;

  // Stack figures.
  localparam logic [15:0]    WORD_STEP    = 16'h0002;
  localparam logic [15:0]    SP_RESET     = 16'h0800;
  localparam logic [15:0]    LIMIT_RESET  = 16'h0000;
  localparam logic [7:0]     BYTE_ZERO    = 8'h00;
  localparam int             PC_MSB       = 7;

  // Kinds of request from the address generator.
  typedef enum logic [2:0] {
    DSP_OP_NONE,
    DSP_OP_ACCESS,
    DSP_OP_PUSH,
    DSP_OP_POP,
    DSP_OP_SP_WRITE
  } dsp_op_e;

  // What a push stores.
  typedef enum logic [1:0] {
    DSP_PUSH_DATA,
    DSP_PUSH_CALL,
    DSP_PUSH_EXC
  } dsp_push_e;

  // Request from the core, one per cycle.
  typedef struct packed {
    dsp_op_e            op;
    dsp_push_e          push_kind;
    logic               indirect;
    logic               is_write;
    logic               via_sp;
    logic [ADDR_W-1:0]  addr;
    logic [15:0]        wdata;
    logic [7:0]         pc_upper;
    logic [7:0]         status_low_byte;
  } dsp_req_s;

  // Writes of the page and limit registers by the core.
  typedef struct packed {
    logic               read_page_we;
    logic               write_page_we;
    logic               limit_we;
    logic [15:0]        wdata;
  } dsp_cfg_s;

  // Answer to the core and exception unit.
  typedef struct packed {
    logic               valid;
    logic               mem_read;
    logic               mem_write;
    logic [EXT_W-1:0]   ext_addr;
    logic [15:0]        wdata;
    logic               addr_err_trap;
    logic               stack_err_trap;
  } dsp_rsp_s;

endpackage : dsp_pkg

//--- verilog/dsp_page_stack_check.sv
// Data-space page translation and software stack supervision.
// Assumes requests and register writes come from logic on the same clock,
// at most one request per cycle; answers appear one cycle later.
`timescale 1ns/100ps

module dsp_page_stack_check
  import dsp_pkg::*;
#(
  parameter logic [15:0] SP_INIT = SP_RESET
)
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Request and register writes from the core.
  input  wire dsp_req_s   req,
  input  wire dsp_cfg_s   cfg,
  // Answer to memory and the exception unit.
  output dsp_rsp_s        rsp,
  output logic [15:0]     stack_pointer_reg,
  output logic [15:0]     stack_limit,
  output logic [8:0]      data_read_page,
  output logic [8:0]      data_write_page
);

  // The stack pointer must start on a word boundary.
  if (SP_INIT[0] != 1'b0)
  begin : g_bad_sp_init
    $error("SP_INIT must be word aligned.");
  end

  // All state of the block.
  typedef struct packed {
    logic [PAGE_W-1:0] read_page;
    logic [PAGE_W-1:0] write_page;
    logic [15:0]       limit;
    logic [15:0]       sp;
    dsp_rsp_s          ans;
  } dsp_state_s;

  dsp_state_s state;
  dsp_state_s next_state;

  // Translates a data access address into the extended space.
  function automatic logic [EXT_W:0] dsp_translate(
    input logic              indirect,
    input logic [ADDR_W-1:0] addr,
    input logic [PAGE_W-1:0] page
  );
    logic [EXT_W:0] res;
    res = '0;
    if (!indirect || addr < PAGED_BASE)
    begin
      // Low half, near region included, bypasses paging entirely.
      res[EXT_W-1:0] = {EXT_HI_ZERO, addr};
    end
    else if (page == PAGE_INVALID)
    begin
      res[EXT_W] = 1'b1;
    end
    else
    begin
      res[EXT_W-1:0] = {page, addr[ADDR_W-2:0]};
    end
    return res;
  endfunction : dsp_translate

  // True when a stack-pointer address leaves the allowed window.
  function automatic logic dsp_stack_bad(
    input logic [15:0] ea,
    input logic [15:0] lim
  );
    return (ea > lim) || (ea < SFR_TOP);
  endfunction : dsp_stack_bad

  // Next-state logic: one request per cycle, answered in the next cycle.
  always_comb
  begin
    logic [EXT_W:0]    xlat;
    logic [PAGE_W-1:0] page;
    logic [15:0]       pop_ea;
    logic [15:0]       push_word;
    logic              bad;
    xlat      = '0;
    page      = '0;
    pop_ea    = '0;
    push_word = '0;
    bad       = 1'b0;
    next_state = state;
    next_state.ans = '0;

    // Register writes take effect for the next request, not this one.
    if (cfg.read_page_we)
    begin
      next_state.read_page = cfg.wdata[PAGE_W-1:0];
    end
    if (cfg.write_page_we)
    begin
      next_state.write_page = cfg.wdata[PAGE_W-1:0];
    end
    if (cfg.limit_we)
    begin
      // A request in this same cycle still checks the old limit.
      next_state.limit = {cfg.wdata[15:1], 1'b0};
    end

    unique case (req.op)
      DSP_OP_NONE:
      begin
        next_state.ans = '0;
      end
      DSP_OP_ACCESS:
      begin
        page = req.is_write ? state.write_page : state.read_page;
        xlat = dsp_translate(req.indirect, req.addr, page);
        bad  = req.via_sp && dsp_stack_bad(req.addr, state.limit);
        next_state.ans.valid          = 1'b1;
        next_state.ans.ext_addr       = xlat[EXT_W-1:0];
        next_state.ans.wdata          = req.wdata;
        next_state.ans.addr_err_trap  = xlat[EXT_W];
        next_state.ans.stack_err_trap = bad;
        next_state.ans.mem_write = req.is_write && !xlat[EXT_W] && !bad;
        next_state.ans.mem_read  = !req.is_write && !xlat[EXT_W] && !bad;
      end
      DSP_OP_PUSH:
      begin
        // Pick the stored word by push kind.
        unique case (req.push_kind)
          DSP_PUSH_CALL:
            push_word = {BYTE_ZERO, 1'b0, req.pc_upper[PC_MSB-1:0]};
          DSP_PUSH_EXC:
            push_word = {req.status_low_byte, req.pc_upper};
          default:
            push_word = req.wdata;
        endcase
        // Write at the free word, then step up.
        bad = dsp_stack_bad(state.sp, state.limit);
        next_state.ans.valid          = 1'b1;
        next_state.ans.ext_addr       = {EXT_HI_ZERO, state.sp};
        next_state.ans.wdata          = push_word;
        next_state.ans.stack_err_trap = bad;
        next_state.ans.mem_write      = !bad;
        if (!bad)
        begin
          next_state.sp = state.sp + WORD_STEP;
        end
      end
      DSP_OP_POP:
      begin
        // Step down first, then read the last pushed word.
        pop_ea = state.sp - WORD_STEP;
        bad    = dsp_stack_bad(pop_ea, state.limit);
        next_state.ans.valid          = 1'b1;
        next_state.ans.ext_addr       = {EXT_HI_ZERO, pop_ea};
        next_state.ans.stack_err_trap = bad;
        next_state.ans.mem_read       = !bad;
        if (!bad)
        begin
          next_state.sp = pop_ea;
        end
      end
      DSP_OP_SP_WRITE:
      begin
        // Pointer stays word aligned like the limit.
        next_state.sp = {req.wdata[15:1], 1'b0};
        next_state.ans.valid = 1'b1;
      end
      default:
      begin
        // Illegal op code: answer nothing and keep state.
        next_state.ans = '0;
      end
    endcase
  end

  // State register; the limit is cleared here although software must set it.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state.read_page  <= '0;
      state.write_page <= '0;
      state.limit      <= LIMIT_RESET;
      state.sp         <= SP_INIT;
      state.ans        <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs come straight from state.
  assign rsp               = state.ans;
  assign stack_pointer_reg = state.sp;
  assign stack_limit       = state.limit;
  assign data_read_page    = state.read_page;
  assign data_write_page   = state.write_page;

endmodule : dsp_page_stack_check

//--- verif/dsp_page_stack_check_asserts.sv
// Checker for the page and stack block.
// Assumes one clock; sees only the block's ports.
`timescale 1ns/100ps
module dsp_check_asserts
  import dsp_pkg::*;
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        arst_n,
  // Watched ports.
  input wire dsp_req_s    req,
  input wire dsp_rsp_s    rsp,
  input wire logic [15:0] stack_pointer_reg,
  input wire logic [15:0] stack_limit,
  input wire logic [8:0]  data_read_page
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Short names; pointer-based reads are left out, and the stack checks here cover only push and pop.
  wire logic [15:0] sp = stack_pointer_reg;
  wire logic [15:0] lim = stack_limit;
  wire logic rd = req.op == DSP_OP_ACCESS && req.indirect && !req.is_write && !req.via_sp;
  wire logic hi = req.addr >= PAGED_BASE;
  wire logic zp = data_read_page == PAGE_INVALID;
  wire logic ok = req.op == DSP_OP_PUSH && sp <= lim && sp >= SFR_TOP;
  // A push that passes both stack checks.
  sequence s_push(dsp_push_e k);
    ok && req.push_kind == k;
  endsequence
  AST_NEAR: assert property (rd && !hi |=> rsp.ext_addr == 24'($past(req.addr)))
    else $error("near read mapped wrongly");
  AST_ZERO: assert property (rd && hi && zp |=> rsp.addr_err_trap && !rsp.mem_read)
    else $error("zero page not trapped");
  AST_PAGE: assert property (rd && hi && !zp |=>
    rsp.ext_addr == {$past(data_read_page), $past(req.addr[14:0])}) else $error("bad page map");
  AST_PUSH: assert property (ok |=> sp == $past(sp) + WORD_STEP && rsp.mem_write)
    else $error("push step wrong");
  AST_CALL: assert property (s_push(DSP_PUSH_CALL) |=>
    rsp.wdata == {BYTE_ZERO, 1'b0, $past(req.pc_upper[6:0])}) else $error("bad call word");
  AST_EXC: assert property (s_push(DSP_PUSH_EXC) |=>
    rsp.wdata == {$past(req.status_low_byte), $past(req.pc_upper)}) else $error("bad exc word");
  AST_OVER: assert property (req.op == DSP_OP_PUSH && sp > lim |=>
    rsp.stack_err_trap && !rsp.mem_write && $stable(sp)) else $error("overflow missed");
  AST_UNDER: assert property (req.op == DSP_OP_POP && sp - WORD_STEP < SFR_TOP |=>
    rsp.stack_err_trap && !rsp.mem_read) else $error("underflow missed");
endmodule : dsp_check_asserts
bind dsp_page_stack_check dsp_check_asserts i_dsp_check_asserts (.clk(clk), .arst_n(arst_n),
  .req(req), .rsp(rsp), .stack_pointer_reg(stack_pointer_reg), .stack_limit(stack_limit),
  .data_read_page(data_read_page));

//--- verif/dsp_core_model.sv
// Core-side model issuing one request per call.
// Assumes a single caller; idles a cycle between calls.
`timescale 1ns/100ps
module dsp_core_model
  import dsp_pkg::*;
(
  // Core clock.
  input wire logic clk,
  // Requests and register writes.
  output dsp_req_s req,
  output dsp_cfg_s cfg
);
  initial req = '0;
  initial cfg = '0;
  // Idle data is inverted so the block cannot lean on stale values.
  task automatic send(input dsp_req_s r, input dsp_cfg_s c);
    @(negedge clk);
    req = r;
    cfg = c;
    @(negedge clk);
    req = {DSP_OP_NONE, ~r[$bits(dsp_req_s)-4:0]};
    cfg = {3'b000, ~c.wdata};
  endtask : send
endmodule : dsp_core_model

//--- verif/dsp_page_stack_check_tb_top.sv
// Self-checking bench for the page and stack block.
// Assumes the core model drives requests and the checker is bound in.
`timescale 1ns/100ps
module dsp_page_stack_check_tb_top
  import dsp_pkg::*;
;
  logic        clk = 1'b0;
  logic        arst_n;
  logic [8:0]  rpg;
  logic [8:0]  wpg;
  dsp_req_s    req;
  dsp_cfg_s    cfg;
  dsp_rsp_s    rsp;
  logic [15:0] sp;
  logic [15:0] lim;
  int          n_errors = 0;
  int          check_count = 0;
  // Core clock, 4 ns period.
  initial forever #2 clk = ~clk;
  dsp_core_model i_dsp_core_model (.clk(clk), .req(req), .cfg(cfg));
  dsp_page_stack_check i_dsp_page_stack_check (.clk(clk), .arst_n(arst_n), .req(req),
    .cfg(cfg), .rsp(rsp), .stack_pointer_reg(sp), .stack_limit(lim), .data_read_page(rpg),
    .data_write_page(wpg));
  // Request with fixed return bytes ffh and status 5ah.
  function automatic dsp_req_s mk(logic [15:0] a, logic d, logic w,
    dsp_op_e o = DSP_OP_ACCESS, dsp_push_e k = DSP_PUSH_DATA);
    return '{o, k, !d, w, 1'b0, a, 16'h1234, 8'hff, 8'h5a};
  endfunction : mk
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Flags are valid, read, write, address error, stack error.
  task automatic run(input dsp_req_s r, input logic [23:0] ea, input logic [4:0] f);
    i_dsp_core_model.send(r, '0);
    chk(24'({rsp.valid, rsp.mem_read, rsp.mem_write, rsp.addr_err_trap,
      rsp.stack_err_trap}), 24'(f));
    if (f[3] | f[2])
      chk(rsp.ext_addr, ea);
  endtask : run
  // Strobes are read page, write page, limit.
  task automatic cfgw(input logic [2:0] we, input logic [15:0] v);
    i_dsp_core_model.send('0, {we, v});
  endtask : cfgw
  // Region edges, with the write page set to one for one write, then back to zero.
  task automatic t_page;
    cfgw(3'b100, 16'h01ff);
    chk(24'(rpg), 24'h0001ff);
    run(mk(16'hffff, 1'b0, 1'b0), 24'hffffff, 5'h18);
    cfgw(3'b010, 16'h0001);
    chk(24'(wpg), 24'h000001);
    run(mk(16'h9000, 1'b0, 1'b1), 24'h009000, 5'h14);
    cfgw(3'b010, 16'h0000);
    chk(24'(wpg), 24'h000000);
    run(mk(16'h7fff, 1'b0, 1'b0), 24'h007fff, 5'h18);
    run(mk(16'h1fff, 1'b1, 1'b0), 24'h001fff, 5'h18);
    run(mk(16'h8000, 1'b0, 1'b1), 24'h0, 5'h12);
    cfgw(3'b100, 16'h0000);
    run(mk(16'h8000, 1'b0, 1'b0), 24'h0, 5'h12);
  endtask : t_page
  // Push to and past the limit, then pop below the bottom.
  task automatic t_stack;
    cfgw(3'b001, 16'h0805);
    chk(24'(lim), 24'h000804);
    run(mk(16'h0, 1'b0, 1'b0, DSP_OP_PUSH), 24'h000800, 5'h14);
    chk(24'(sp), 24'h000802);
    run(mk(16'h0, 1'b0, 1'b0, DSP_OP_PUSH, DSP_PUSH_CALL), 24'h000802, 5'h14);
    chk(24'(rsp.wdata), 24'h00007f);
    run(mk(16'h0, 1'b0, 1'b0, DSP_OP_PUSH, DSP_PUSH_EXC), 24'h000804, 5'h14);
    chk(24'(rsp.wdata), 24'h005aff);
    run(mk(16'h0, 1'b0, 1'b0, DSP_OP_PUSH), 24'h0, 5'h11);
    chk(24'(sp), 24'h000806);
    for (int i = 4; i >= 0; i -= 2)
      run(mk(16'h0, 1'b0, 1'b0, DSP_OP_POP), 24'h000800 + 24'(i), 5'h18);
    run(mk(16'h0, 1'b0, 1'b0, DSP_OP_POP), 24'h0, 5'h11);
    chk(24'(sp), 24'h000800);
  endtask : t_stack
  // Prints the counts and the verdict, then stops.
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // Two cycles of reset, release on a falling edge, then the scenarios.
  initial
  begin
    // Driven at time zero so the block sees a real falling edge of reset.
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    t_page();
    t_stack();
    print_verdict();
  end
  // The scenarios need under 100 cycles, so 500 means a hang.
  initial
  begin
    #2000;
    n_errors++;
    print_verdict();
  end
endmodule : dsp_page_stack_check_tb_top
